// File: src/lcc_pkg.sv
// constants, command codes and carrier types for the lan controller command block
// assumes one board clock; shared by the design and the bench
package lcc_pkg;
  localparam int unsigned FIFO_AW = 8;
  localparam int unsigned FIFO_DEPTH = 256;
  localparam int unsigned FCS_BYTES = 4;
  localparam logic [2:0] FCS_LAST_IDX = 3'h3;
  localparam logic [2:0] FCS_FIRST_IDX = 3'h0;
  localparam logic [7:0] FCS_FILL = 8'h00;

  localparam logic [3:0] OFF_CMD = 4'h0;
  localparam logic [3:0] OFF_RX_DATA = 4'h1;
  localparam logic [3:0] OFF_CNT_HI = 4'hc;
  localparam logic [3:0] OFF_CNT_LO = 4'hd;

  localparam logic [7:0] CMD_RESERVED = 8'h00;
  localparam logic [7:0] CMD_MI_LOOP = 8'h01;
  localparam logic [7:0] CMD_INT_LOOP = 8'h02;
  localparam logic [7:0] CMD_CLR_LOOP = 8'h03;
  localparam logic [7:0] CMD_SET_PROMISC = 8'h04;
  localparam logic [7:0] CMD_CLR_PROMISC = 8'h05;
  localparam logic [7:0] CMD_GO_ONLINE = 8'h09;
  localparam logic [7:0] CMD_LOAD_SEND = 8'h29;
  localparam logic [7:0] STS_OK = 8'h00;

  localparam logic [3:0] CNT_HI_RST = 4'h0;
  localparam logic [7:0] CNT_LO_RST = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] data;
  } lcc_io_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } lcc_byte_t;

  typedef struct packed {
    logic offline;
    logic mi_loop;
    logic int_loop;
    logic promisc;
    logic led;
  } lcc_mode_t;

  typedef enum logic [1:0] {ST_IDLE, ST_NET, ST_LOOP, ST_FCS} lcc_rx_st_t;
endpackage : lcc_pkg

// File: src/lcc_cmd_ctrl.sv
// command decode, byte count registers, receive path selection and receive memory
// assumes host i/o strobes and frame streams synchronous to ref_clk
// Contract
// [R01] high count write keeps bits 3..0 as count upper nibble, ignores 7..4
// [R02] host loads count with transmit block size before transmit dma
// [R03] host loads count with receive block size before receive dma
// [R04] host never writes reserved command code 00h
// [R05] command written at base offset is decoded and executed
// [R06] 01h: module loopback, offline, status 00h
// [R07] in loopback, 29h loops transmit frame into receive memory and data register
// [R08] looped frame clears block-available-n, sets data-full, enabled interrupts raised
// [R09] module loopback skips crc; returned frame carries meaningless fcs
// [R10] 02h: internal loopback, offline, led on, status 00h
// [R11] internal loopback frames pass address filter before being queued
// [R12] frames already queued come out before loopback frames
// [R13] loopback frame without whole room in receive fifo is discarded
// [R14] 03h: leave loopback, led off, stay offline, status 00h
// [R15] 04h: accept all valid frames, runts rejected, status 00h
// [R16] promiscuous mode also receives own transmissions
// [R17] 05h: only physical, multicast or broadcast matches accepted
// [R18] leaving promiscuous reports status 00h
// [R19] after clearing loopback only go-online 09h restores network access
// [R20] reset selects normal filtering, not promiscuous
`timescale 1ns/1ps
`default_nettype none
module lcc_cmd_ctrl (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire lcc_pkg::lcc_io_t io,
  input wire lcc_pkg::lcc_byte_t tx,
  input wire logic [11:0] tx_len,
  input wire lcc_pkg::lcc_byte_t net,
  input wire logic net_runt,
  input wire logic net_own,
  input wire logic flt_match,
  input wire logic rba_irq_en,
  input wire logic rdf_irq_en,
  output logic tx_ready,
  output lcc_pkg::lcc_mode_t mode,
  output logic [11:0] host_count,
  output logic status_valid,
  output logic [7:0] status_code,
  output logic [7:0] rx_data,
  output logic rx_data_full,
  output logic rx_block_avail_n,
  output logic irq_rba,
  output logic irq_rdf
);
  import lcc_pkg::*;

  logic [8:0] mem [FIFO_DEPTH];
  logic [FIFO_AW:0] wr_ptr, wr_tmp, rd_ptr, used;
  logic [12:0] free, need;
  lcc_rx_st_t st;
  logic keep, loop_pass, loop_pend, rd_last;
  logic [2:0] fcs_idx;
  logic [FIFO_AW:0] frames, next_frames;
  logic cmd_wr, send_req, host_rd, full, net_take, loop_take, fcs_take;
  logic byte_take, keep_now, wr_fire, wr_last, frame_end, accept;
  logic [7:0] wr_data;
  logic avail, rd_take, next_full;

  assign cmd_wr = io.wr && io.addr == OFF_CMD;
  assign host_rd = io.rd && io.addr == OFF_RX_DATA && rx_data_full;

  // [R01] count upper nibble
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_count <= {CNT_HI_RST, CNT_LO_RST};
    end else if (io.wr && io.addr == OFF_CNT_HI) begin
      host_count[11:8] <= io.data[3:0];
    end else if (io.wr && io.addr == OFF_CNT_LO) begin
      host_count[7:0] <= io.data;
    end
  end

  // [R05] command decode
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // [R20] normal filtering at reset
      mode <= '{offline: 1'b1, mi_loop: 1'b0, int_loop: 1'b0, promisc: 1'b0, led: 1'b0};
    end else if (cmd_wr) begin
      unique case (io.data)
        // [R06] module loopback
        CMD_MI_LOOP: begin
          mode.mi_loop <= 1'b1;
          mode.int_loop <= 1'b0;
          mode.offline <= 1'b1;
        end
        // [R10] internal loopback
        CMD_INT_LOOP: begin
          mode.int_loop <= 1'b1;
          mode.mi_loop <= 1'b0;
          mode.offline <= 1'b1;
          mode.led <= 1'b1;
        end
        // [R14] clear loopback
        CMD_CLR_LOOP: begin
          mode.mi_loop <= 1'b0;
          mode.int_loop <= 1'b0;
          mode.led <= 1'b0;
        end
        // [R15] promiscuous on
        CMD_SET_PROMISC: mode.promisc <= 1'b1;
        // [R17] promiscuous off
        CMD_CLR_PROMISC: mode.promisc <= 1'b0;
        // [R19] only go-online reconnects
        CMD_GO_ONLINE: mode.offline <= 1'b0;
        default: ;
      endcase
    end
  end

  // [R18] success status for handled mode commands
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_valid <= 1'b0;
      status_code <= STS_OK;
    end else begin
      status_valid <= cmd_wr && io.data != CMD_RESERVED && io.data != CMD_LOAD_SEND
                      && io.data <= CMD_GO_ONLINE && (io.data <= CMD_CLR_PROMISC || io.data == CMD_GO_ONLINE);
      status_code <= STS_OK;
    end
  end

  // [R07] send in loopback queues a looped frame
  assign send_req = cmd_wr && io.data == CMD_LOAD_SEND && (mode.mi_loop || mode.int_loop);

  // receive write side
  assign used = wr_tmp - rd_ptr;
  assign full = used[FIFO_AW];
  assign free = 13'(FIFO_DEPTH) - 13'(used);
  assign need = 13'(tx_len) + 13'(FCS_BYTES);
  assign net_take = net.valid && (st == ST_NET || (st == ST_IDLE && !loop_pend && !mode.offline));
  assign loop_take = st == ST_LOOP && tx.valid && tx_ready;
  assign fcs_take = st == ST_FCS;
  assign byte_take = net_take || loop_take || fcs_take;
  assign keep_now = (st == ST_IDLE) ? 1'b1 : keep;
  assign wr_fire = byte_take && keep_now && !full;
  // [R09] fcs bytes appended without crc generation
  assign wr_data = fcs_take ? FCS_FILL : (loop_take ? tx.data : net.data);
  assign wr_last = fcs_take ? fcs_idx == FCS_LAST_IDX : (net_take && net.last);
  assign frame_end = (net_take && net.last) || (fcs_take && fcs_idx == FCS_LAST_IDX);
  // [R15] runts never accepted
  // [R16] own frames only in promiscuous
  // [R11] internal loopback filtered, module loopback not
  assign accept = keep_now && !(byte_take && full) && (fcs_take ? loop_pass
                  : (!net_runt && (mode.promisc || (flt_match && !net_own))));

  always_ff @(posedge ref_clk) begin
    if (wr_fire) begin
      mem[wr_tmp[FIFO_AW-1:0]] <= {wr_last, wr_data};
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      loop_pend <= 1'b0;
    end else if (send_req) begin
      loop_pend <= 1'b1;
    end else if (st == ST_IDLE) begin
      loop_pend <= 1'b0;
    end
  end

  // [R12] one shared fifo, a loop frame waits for the current network frame
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= ST_IDLE;
      keep <= 1'b0;
      tx_ready <= 1'b0;
      fcs_idx <= FCS_FIRST_IDX;
      loop_pass <= 1'b0;
    end else begin
      unique case (st)
        ST_IDLE: begin
          if (loop_pend) begin
            st <= ST_LOOP;
            tx_ready <= 1'b1;
            // [R13] drop a loop frame that cannot fit whole
            keep <= free >= need;
          end else if (net_take && !net.last) begin
            st <= ST_NET;
            keep <= !full;
          end
        end
        ST_NET: begin
          if (net.valid && full) begin
            keep <= 1'b0;
          end
          if (net.valid && net.last) begin
            st <= ST_IDLE;
          end
        end
        ST_LOOP: begin
          if (loop_take && full) begin
            keep <= 1'b0;
          end
          if (loop_take && tx.last) begin
            st <= ST_FCS;
            tx_ready <= 1'b0;
            fcs_idx <= FCS_FIRST_IDX;
            loop_pass <= mode.mi_loop || flt_match || mode.promisc;
          end
        end
        ST_FCS: begin
          if (full) begin
            keep <= 1'b0;
          end
          fcs_idx <= fcs_idx + 3'h1;
          if (fcs_idx == FCS_LAST_IDX) begin
            st <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // commit a kept frame, roll back a rejected one
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      wr_tmp <= '0;
    end else if (frame_end) begin
      if (accept) begin
        wr_ptr <= wr_tmp + 9'h1;
        wr_tmp <= wr_tmp + 9'h1;
      end else begin
        wr_tmp <= wr_ptr;
      end
    end else if (wr_fire) begin
      wr_tmp <= wr_tmp + 9'h1;
    end
  end

  // receive data register
  assign avail = rd_ptr != wr_ptr;
  assign rd_take = avail && (!rx_data_full || host_rd);
  assign next_full = rd_take || (rx_data_full && !host_rd);
  assign next_frames = frames + {8'h00, frame_end && accept} - {8'h00, host_rd && rd_last};

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr <= '0;
      rx_data <= 8'h00;
      rd_last <= 1'b0;
      rx_data_full <= 1'b0;
    end else begin
      // [R08] data-full set wins over host read
      rx_data_full <= next_full;
      if (rd_take) begin
        rx_data <= mem[rd_ptr[FIFO_AW-1:0]][7:0];
        rd_last <= mem[rd_ptr[FIFO_AW-1:0]][8];
        rd_ptr <= rd_ptr + 9'h1;
      end
    end
  end

  // [R08] block available and interrupts
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frames <= '0;
      rx_block_avail_n <= 1'b1;
      irq_rba <= 1'b0;
      irq_rdf <= 1'b0;
    end else begin
      frames <= next_frames;
      rx_block_avail_n <= next_frames == '0;
      irq_rba <= rba_irq_en && next_frames != '0;
      irq_rdf <= rdf_irq_en && next_full;
    end
  end

  // assertions
  AST_CNT_HI: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R01]
    io.wr && io.addr == OFF_CNT_HI |=> host_count[11:8] == $past(io.data[3:0]))
    else $error("count upper nibble not taken");
  AST_MI_LOOP: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R06]
    cmd_wr && io.data == CMD_MI_LOOP |=> mode.mi_loop && mode.offline && status_valid && status_code == STS_OK)
    else $error("module loopback command mishandled");
  AST_INT_LOOP: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R10]
    cmd_wr && io.data == CMD_INT_LOOP |=> mode.int_loop && mode.led && mode.offline && !mode.mi_loop)
    else $error("internal loopback command mishandled");
  AST_CLR_LOOP: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R14]
    cmd_wr && io.data == CMD_CLR_LOOP |=> !mode.mi_loop && !mode.int_loop && !mode.led
      && mode.offline == $past(mode.offline))
    else $error("clear loopback mishandled");
  AST_PROMISC: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R15]
    cmd_wr && io.data == CMD_SET_PROMISC |=> mode.promisc && status_valid)
    else $error("promiscuous set mishandled");
  AST_NORMAL: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R18]
    cmd_wr && io.data == CMD_CLR_PROMISC |=> !mode.promisc && status_valid && status_code == STS_OK)
    else $error("promiscuous clear mishandled");
  AST_RUNT: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R15]
    net_take && net.last && net_runt |=> wr_ptr == $past(wr_ptr))
    else $error("runt frame committed");
  AST_NO_ROOM: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R13]
    st == ST_IDLE && loop_pend && free < need |=> !keep)
    else $error("oversize loop frame kept");
  AST_RBA: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R08]
    frame_end && accept |=> !rx_block_avail_n ##[1:2] rx_data_full)
    else $error("accepted frame not flagged");
  AST_OFFLINE: assert property (@(posedge ref_clk) disable iff (sys_rst) // [R19]
    mode.offline && !(cmd_wr && io.data == CMD_GO_ONLINE) |=> mode.offline)
    else $error("went online without go-online");
  AST_RESET_MODE: assert property (@(posedge ref_clk) // [R20]
    $fell(sys_rst) |-> !mode.promisc && mode.offline)
    else $error("reset mode wrong");

  COV_LOOP_FRAME: cover property (@(posedge ref_clk) disable iff (sys_rst)
    st == ST_FCS && frame_end && accept);
  COV_LOOP_DROP: cover property (@(posedge ref_clk) disable iff (sys_rst)
    st == ST_IDLE && loop_pend && free < need);
  COV_NET_FRAME: cover property (@(posedge ref_clk) disable iff (sys_rst)
    net_take && net.last && accept);
endmodule : lcc_cmd_ctrl
`default_nettype wire

// File: verif/lcc_host_model.sv
// host processor model: i/o writes and receive data reads
// assumes the block samples io on rising ref_clk edges
`timescale 1ns/1ps
`default_nettype none
module lcc_host_model (
  input wire logic ref_clk,
  input wire logic rx_data_full,
  input wire logic [7:0] rx_data,
  output var lcc_pkg::lcc_io_t io
);
  import lcc_pkg::*;
  initial io = '0;
  // one-cycle write; reserved 00h never sent
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 io = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge ref_clk);
    #1 io = '0;
  endtask : wr
  // waits for a full data register, then reads it
  task rd(output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge ref_clk);
      #1 ok = (rx_data_full === 1'b1);
    end
    if (ok) begin
      io = '{wr: 1'b0, rd: 1'b1, addr: OFF_RX_DATA, data: 8'h00};
      // data register holds still while full, so take it before the read edge
      d = rx_data;
      @(posedge ref_clk);
      #1 io = '0;
    end
  endtask : rd
endmodule : lcc_host_model
`default_nettype wire

// File: verif/lan_ctrl_count_and_mode_cmds_test.sv
// self-checking bench for the command, count and receive path block
// assumes the host model drives io; bench drives tx and network streams
`timescale 1ns/1ps
`default_nettype none
module lan_ctrl_count_and_mode_cmds_test;
  import lcc_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  lcc_io_t io;
  lcc_byte_t tx = '0;
  lcc_byte_t net = '0;
  logic [11:0] tx_len = 12'h004;
  logic net_runt = 1'b0;
  logic net_own = 1'b0;
  logic flt_match = 1'b0;
  logic rba_irq_en = 1'b1;
  logic rdf_irq_en = 1'b1;
  logic tx_ready, status_valid, rx_data_full, rx_block_avail_n, irq_rba, irq_rdf;
  lcc_mode_t mode;
  logic [11:0] host_count;
  logic [7:0] status_code, rx_data;
  int n_fail = 0;
  int samples_checked = 0;
  lcc_cmd_ctrl lcc_cmd_ctrl_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .io(io), .tx(tx), .tx_len(tx_len),
    .net(net), .net_runt(net_runt), .net_own(net_own), .flt_match(flt_match), .rba_irq_en(rba_irq_en),
    .rdf_irq_en(rdf_irq_en), .tx_ready(tx_ready), .mode(mode), .host_count(host_count),
    .status_valid(status_valid), .status_code(status_code), .rx_data(rx_data), .rx_data_full(rx_data_full),
    .rx_block_avail_n(rx_block_avail_n), .irq_rba(irq_rba), .irq_rdf(irq_rdf));
  lcc_host_model lcc_host_model_inst (.ref_clk(ref_clk), .rx_data_full(rx_data_full), .rx_data(rx_data), .io(io));
  initial forever #2.5 ref_clk = ~ref_clk;
  task final_report;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  task chk(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task timeout;
    n_fail++;
    $display("ERROR %0t wait ran out", $time);
    final_report;
  endtask : timeout
  task cmd(input logic [7:0] code, input logic [4:0] exp, input logic sts);
    lcc_host_model_inst.wr(OFF_CMD, code);
    chk(12'(status_valid), 12'(sts));
    if (sts) chk(12'(status_code), 12'(STS_OK));
    chk(12'(mode), 12'(exp));
  endtask : cmd
  task send_tx(input int n);
    int k;
    logic rdy;
    k = 0;
    rdy = tx_ready;
    tx = lcc_byte_t'{valid: 1'b1, last: (n == 1), data: 8'h10};
    for (int i = 0; i < n + 60 && k < n; i++) begin
      @(posedge ref_clk);
      if (rdy === 1'b1) k++;
      #1 tx = (k >= n) ? lcc_byte_t'('0) : lcc_byte_t'{valid: 1'b1, last: (k == n - 1), data: 8'(8'h10 + k)};
      rdy = tx_ready;
    end
    if (k < n) timeout;
  endtask : send_tx
  task send_net(input int n, input logic runt, input logic own, input logic match);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #1 net = '{valid: 1'b1, last: (i == n - 1), data: 8'(8'h40 + i)};
      net_runt = runt && (i == n - 1);
      net_own = own;
      flt_match = match;
    end
    @(posedge ref_clk);
    #1 net = '0;
  endtask : send_net
  task wait_frame(input logic exp);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 30 && !seen; i++) begin
      @(posedge ref_clk);
      #1 seen = (rx_block_avail_n === 1'b0);
    end
    chk(12'(seen), 12'(exp));
  endtask : wait_frame
  task rd_frame(input int nd, input int nf, input logic [7:0] base);
    logic [7:0] d;
    logic ok;
    for (int i = 0; i < nd + nf; i++) begin
      lcc_host_model_inst.rd(d, ok);
      if (!ok) timeout;
      chk(12'(d), (i < nd) ? 12'(base + 8'(i)) : 12'(FCS_FILL));
    end
  endtask : rd_frame
  task count_regs;
    lcc_host_model_inst.wr(OFF_CNT_HI, 8'ha5);
    lcc_host_model_inst.wr(OFF_CNT_LO, 8'h3c);
    chk(host_count, 12'h53c);
    lcc_host_model_inst.wr(OFF_CNT_HI, 8'hff);
    chk(host_count, 12'hf3c);
  endtask : count_regs
  task mode_cmds;
    cmd(CMD_MI_LOOP, 5'b11000, 1'b1);
    cmd(CMD_CLR_LOOP, 5'b10000, 1'b1);
    cmd(CMD_INT_LOOP, 5'b10101, 1'b1);
    cmd(CMD_CLR_LOOP, 5'b10000, 1'b1);
    cmd(CMD_SET_PROMISC, 5'b10010, 1'b1);
    cmd(CMD_CLR_PROMISC, 5'b10000, 1'b1);
    cmd(CMD_LOAD_SEND, 5'b10000, 1'b0);
    cmd(CMD_GO_ONLINE, 5'b00000, 1'b1);
  endtask : mode_cmds
  task mi_loop_frame;
    cmd(CMD_MI_LOOP, 5'b11000, 1'b1);
    lcc_host_model_inst.wr(OFF_CMD, CMD_LOAD_SEND);
    send_tx(4);
    wait_frame(1'b1);
    repeat (3) @(posedge ref_clk);
    #1 chk(12'({rx_data_full, irq_rba, irq_rdf}), 12'h007);
    rd_frame(4, FCS_BYTES, 8'h10);
    repeat (3) @(posedge ref_clk);
    #1 chk(12'(rx_block_avail_n), 12'h001);
  endtask : mi_loop_frame
  task int_loop_filter;
    cmd(CMD_CLR_LOOP, 5'b10000, 1'b1);
    cmd(CMD_INT_LOOP, 5'b10101, 1'b1);
    flt_match = 1'b0;
    lcc_host_model_inst.wr(OFF_CMD, CMD_LOAD_SEND);
    send_tx(4);
    wait_frame(1'b0);
    flt_match = 1'b1;
    // frame plus fcs is one byte more than an empty receive fifo holds
    tx_len = 12'h0fd;
    lcc_host_model_inst.wr(OFF_CMD, CMD_LOAD_SEND);
    send_tx(253);
    wait_frame(1'b0);
    tx_len = 12'h004;
    rba_irq_en = 1'b0;
    lcc_host_model_inst.wr(OFF_CMD, CMD_LOAD_SEND);
    send_tx(4);
    wait_frame(1'b1);
    repeat (2) @(posedge ref_clk);
    #1 chk(12'({irq_rba, irq_rdf}), 12'h001);
    rba_irq_en = 1'b1;
    rd_frame(4, FCS_BYTES, 8'h10);
  endtask : int_loop_filter
  task net_filter;
    cmd(CMD_CLR_LOOP, 5'b10000, 1'b1);
    cmd(CMD_GO_ONLINE, 5'b00000, 1'b1);
    cmd(CMD_SET_PROMISC, 5'b00010, 1'b1);
    send_net(6, 1'b0, 1'b1, 1'b0);
    wait_frame(1'b1);
    rd_frame(6, 0, 8'h40);
    send_net(6, 1'b1, 1'b0, 1'b1);
    wait_frame(1'b0);
    cmd(CMD_CLR_PROMISC, 5'b00000, 1'b1);
    send_net(6, 1'b0, 1'b0, 1'b0);
    wait_frame(1'b0);
    send_net(6, 1'b0, 1'b0, 1'b1);
    wait_frame(1'b1);
    // network frame still queued when internal loopback starts
    cmd(CMD_INT_LOOP, 5'b10101, 1'b1);
    lcc_host_model_inst.wr(OFF_CMD, CMD_LOAD_SEND);
    send_tx(4);
    rd_frame(6, 0, 8'h40);
    rd_frame(4, FCS_BYTES, 8'h10);
  endtask : net_filter
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    chk(12'(mode), 12'h010);
    chk(12'({host_count, rx_block_avail_n}), 12'h001);
    count_regs;
    mode_cmds;
    mi_loop_frame;
    int_loop_filter;
    net_filter;
    final_report;
  end
endmodule : lan_ctrl_count_and_mode_cmds_test
`default_nettype wire
